// File: rtl/cgn_ctrl.sv
`timescale 1ns/1ps
module cgn_ctrl
	import cgn_pkg::*;
#(
	parameter int NUM_IN          = 4,
	parameter int NVM_PROG_CYCLES = NVM_PROG_CYC
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire logic              restart_pin_n,
	// Serial register port
	input  wire logic              spiCsN,
	input  wire logic              spiSck,
	input  wire logic              spiMosi,
	output logic                   spiMiso,
	output logic                   spiMisoOe,
	// Straps and loop status
	input  wire logic              factoryPlan,
	input  wire logic [NUM_IN-1:0] clkInValid,
	input  wire logic              lockAcquired,
	input  wire logic              history_valid_flag,
	// Loop control
	output logic                   clkOutEnable,
	output cgn_loop_t              loopMode,
	output logic                   fastBandwidthSel,
	output logic                   crystalRefOnly
);
	localparam int MEM_DEPTH = NVM_BANKS * CFG_BYTES;
	localparam int MEM_AW    = $clog2(MEM_DEPTH);

	typedef struct packed {
		cgn_ctl_t                        ctl;
		logic [15:0]                     cnt;
		logic [7:0]                      page;
		logic [CFG_BYTES-1:0][7:0]       cfg;
		logic                            fastApplied;
		logic [1:0]                      writesDone;
		cgn_loop_t                       mode;
		logic                            fastSel;
		logic                            outEn;
		logic [1:0]                      csS;
		logic [2:0]                      sckS;
		logic [1:0]                      mosiS;
		logic [1:0]                      pinS;
		logic [1:0]                      strapS;
		logic [NUM_IN-1:0]               validS1;
		logic [NUM_IN-1:0]               validS2;
		logic [1:0]                      lockS;
		logic [1:0]                      histS;
		logic [4:0]                      bitCnt;
		logic [23:0]                     shIn;
		logic [7:0]                      shOut;
		logic                            miso;
		logic                            misoOe;
	} cgn_st_t;

	cgn_st_t             st_ff;
	cgn_st_t             nxt_st;
	logic [MEM_AW-1:0]   memWrAddr;
	logic [MEM_AW-1:0]   memRdAddr;
	logic [7:0]          memWrData;
	logic [7:0]          memRdData;
	logic                memWrEn;
	logic                hardReq;
	logic                keyWr;
	logic                rdLoad;
	logic                anyValid;
	logic                sckRise;
	logic                sckFall;
	logic [7:0]          readyByte;
	logic [7:0]          rdByte;
	logic [7:0]          wrData;
	logic [7:0]          rdLo;
	logic [15:0]         rdFull;
	logic [15:0]         wrFull;
	logic [4:0]          rdIdx;
	logic [4:0]          wrIdx;
	logic [4:0]          ldIdx;
	logic [1:0]          writeLimit;
	logic [7:0]          ldByte;

	cgn_nvm_mem #(
		.WIDTH (8),
		.DEPTH (MEM_DEPTH),
		.AW    (MEM_AW)
	) u_mem (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.wrEn    (memWrEn),
		.wrAddr  (memWrAddr),
		.wrData  (memWrData),
		.rdAddr  (memRdAddr),
		.rdData  (memRdData)
	);

	assign anyValid   = |st_ff.validS2;
	assign sckRise    = st_ff.sckS[1] && !st_ff.sckS[2];
	assign sckFall    = !st_ff.sckS[1] && st_ff.sckS[2];
	assign writeLimit = st_ff.strapS[1] ? WRITES_PRE : WRITES_BLANK;
	assign readyByte  = (st_ff.ctl == CTL_RUN) ? READY_CODE : BUSY_CODE;

	// Read mux; triggers are write-only and read zero
	assign rdLo   = {st_ff.shIn[6:0], st_ff.mosiS[1]};
	assign rdFull = {st_ff.page, rdLo};
	assign rdIdx  = cgn_cfg_idx(rdFull);
	always_comb begin
		if (rdLo == READY_OFS) begin
			rdByte = readyByte;
		end else if (rdLo == PAGE_OFS) begin
			rdByte = st_ff.page;
		end else if (rdFull == BANK_ADDR) begin
			rdByte = {6'h00, st_ff.writesDone};
		end else if (int'(rdIdx) < CFG_BYTES) begin
			rdByte = st_ff.cfg[rdIdx];
		end else begin
			rdByte = 8'h00;
		end
	end

	assign wrFull = {st_ff.page, st_ff.shIn[14:7]};
	assign wrData = {st_ff.shIn[6:0], st_ff.mosiS[1]};
	assign wrIdx  = cgn_cfg_idx(wrFull);
	assign ldIdx  = 5'(st_ff.cnt - 16'h0001);
	assign ldByte = (st_ff.writesDone == 2'h0) ? cgn_cfg_default(ldIdx) : memRdData;

	always_comb begin
		nxt_st    = st_ff;
		hardReq   = 1'b0;
		keyWr     = 1'b0;
		rdLoad    = 1'b0;
		memWrEn   = 1'b0;
		memWrData = 8'h00;
		memWrAddr = MEM_AW'(int'(st_ff.writesDone) * CFG_BYTES + int'(st_ff.cnt));
		memRdAddr = MEM_AW'(int'(st_ff.writesDone) * CFG_BYTES - CFG_BYTES + int'(st_ff.cnt));
		nxt_st.csS     = {st_ff.csS[0], spiCsN};
		nxt_st.sckS    = {st_ff.sckS[1:0], spiSck};
		nxt_st.mosiS   = {st_ff.mosiS[0], spiMosi};
		nxt_st.pinS    = {st_ff.pinS[0], restart_pin_n};
		nxt_st.strapS  = {st_ff.strapS[0], factoryPlan};
		nxt_st.validS1 = clkInValid;
		nxt_st.validS2 = st_ff.validS1;
		nxt_st.lockS   = {st_ff.lockS[0], lockAcquired};
		nxt_st.histS   = {st_ff.histS[0], history_valid_flag};

		// Serial slave, silent until initialization ends
		if (st_ff.csS[1] || st_ff.ctl == CTL_INIT) begin
			nxt_st.bitCnt = 5'h00;
			nxt_st.misoOe = 1'b0;
			nxt_st.miso   = 1'b0;
		end else begin
			nxt_st.misoOe = 1'b1;
			if (sckRise && st_ff.bitCnt < SPI_FRAME_BITS) begin
				nxt_st.shIn   = {st_ff.shIn[22:0], st_ff.mosiS[1]};
				nxt_st.bitCnt = st_ff.bitCnt + 5'h01;
				if (st_ff.bitCnt == SPI_HDR_LAST) begin
					rdLoad       = 1'b1;
					nxt_st.shOut = st_ff.shIn[14] ? rdByte : 8'h00;
				end
				// Writes while busy are dropped
				if (st_ff.bitCnt == SPI_FRAME_LAST && !st_ff.shIn[22]
				    && st_ff.ctl == CTL_RUN) begin
					if (wrFull[7:0] == PAGE_OFS) begin
						nxt_st.page = wrData;
					end else if (wrFull == HARD_RST_ADDR) begin
						hardReq = wrData[HARD_BIT];
					end else if (wrFull == SOFT_RST_ADDR) begin
						if (wrData[SOFT_BIT]) nxt_st.ctl = CTL_SOFT;
					end else if (wrFull == KEY_ADDR) begin
						keyWr = 1'b1;
						if (wrData == WRITE_KEY && st_ff.writesDone < writeLimit) begin
							nxt_st.ctl = CTL_PROG;
							nxt_st.cnt = 16'h0000;
						end
					end else if (wrFull == RELOAD_ADDR) begin
						if (wrData[RELOAD_BIT]) begin
							nxt_st.ctl = CTL_RELOAD;
							nxt_st.cnt = 16'h0000;
						end
					end else if (int'(wrIdx) < CFG_BYTES) begin
						nxt_st.cfg[wrIdx] = wrData;
					end
				end
			end
			if (sckFall && st_ff.bitCnt >= SPI_DATA_FIRST) begin
				nxt_st.miso  = st_ff.shOut[7];
				nxt_st.shOut = {st_ff.shOut[6:0], 1'b0};
			end
		end

		case (st_ff.ctl)
			CTL_INIT, CTL_RELOAD: begin
				// Newest bank, or factory image when none written
				if (st_ff.cnt != 16'h0000) begin
					nxt_st.cfg[ldIdx] = ldByte;
				end
				if (st_ff.cnt == 16'(CFG_BYTES)) begin
					nxt_st.ctl         = CTL_RUN;
					nxt_st.cnt         = 16'h0000;
					nxt_st.fastApplied = nxt_st.cfg[CFG_FAST][FAST_BIT];
					nxt_st.outEn       = 1'b1;
				end else begin
					nxt_st.cnt = st_ff.cnt + 16'h0001;
				end
			end
			CTL_PROG: begin
				if (st_ff.cnt < 16'(CFG_BYTES)) begin
					memWrEn   = 1'b1;
					memWrData = st_ff.cfg[st_ff.cnt[4:0]];
				end
				// New bank becomes the only reachable one
				if (st_ff.cnt == 16'(CFG_BYTES - 1 + NVM_PROG_CYCLES)) begin
					nxt_st.writesDone = st_ff.writesDone + 2'h1;
					nxt_st.ctl        = CTL_RUN;
					nxt_st.cnt        = 16'h0000;
				end else begin
					nxt_st.cnt = st_ff.cnt + 16'h0001;
				end
			end
			CTL_SOFT: begin
				nxt_st.fastApplied = st_ff.cfg[CFG_FAST][FAST_BIT];
				nxt_st.mode        = LOOP_FREERUN;
				nxt_st.ctl         = CTL_RUN;
			end
			CTL_RUN: begin
			end
			default: begin
				nxt_st.ctl = CTL_INIT;
				nxt_st.cnt = 16'h0000;
			end
		endcase

		// Loop mode machine, held in free-run until initialized
		if (st_ff.ctl == CTL_INIT) begin
			nxt_st.mode = LOOP_FREERUN;
		end else if (st_ff.ctl != CTL_SOFT) begin
			case (st_ff.mode)
				LOOP_FREERUN: begin
					if (anyValid) nxt_st.mode = LOOP_ACQUIRE;
				end
				LOOP_ACQUIRE, LOOP_LOCKED: begin
					if (!anyValid) begin
						nxt_st.mode = st_ff.histS[1] ? LOOP_HOLDOVER : LOOP_FREERUN;
					end else if (st_ff.lockS[1]) begin
						nxt_st.mode = LOOP_LOCKED;
					end else begin
						nxt_st.mode = LOOP_ACQUIRE;
					end
				end
				LOOP_HOLDOVER: begin
					if (anyValid) nxt_st.mode = LOOP_ACQUIRE;
				end
				default: begin
					nxt_st.mode = LOOP_FREERUN;
				end
			endcase
		end

		// Hard reset from pin or control bit restarts everything
		if (!st_ff.pinS[1] || hardReq) begin
			nxt_st.ctl    = CTL_INIT;
			nxt_st.cnt    = 16'h0000;
			nxt_st.page   = 8'h00;
			nxt_st.outEn  = 1'b0;
			nxt_st.mode   = LOOP_FREERUN;
			nxt_st.bitCnt = 5'h00;
			nxt_st.misoOe = 1'b0;
			nxt_st.miso   = 1'b0;
		end
		nxt_st.fastSel = (nxt_st.mode == LOOP_ACQUIRE) && nxt_st.fastApplied;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff      <= '0;
			st_ff.pinS <= 2'h3;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign spiMiso          = st_ff.miso;
	assign spiMisoOe        = st_ff.misoOe;
	assign clkOutEnable     = st_ff.outEn;
	assign loopMode         = st_ff.mode;
	assign fastBandwidthSel = st_ff.fastSel;
	assign crystalRefOnly   = st_ff.outEn && st_ff.mode == LOOP_FREERUN;

	localparam int PROG_BOUND = CFG_BYTES + NVM_PROG_CYCLES;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	a_outputs_held: assert property (st_ff.ctl == CTL_INIT |-> !clkOutEnable)
		else $error("clock outputs enabled during initialization");
	a_init_quiet: assert property (st_ff.ctl == CTL_INIT |=> !spiMisoOe && st_ff.bitCnt == 5'h00)
		else $error("serial port active during initialization");
	a_init_freerun: assert property (st_ff.ctl == CTL_INIT ##1 st_ff.ctl == CTL_RUN
		|-> loopMode == LOOP_FREERUN && clkOutEnable)
		else $error("loop not in free-run after initialization");
	a_acq_start: assert property (st_ff.ctl == CTL_RUN && st_ff.mode == LOOP_FREERUN && anyValid
		&& st_ff.pinS[1] && !hardReq |=> loopMode == LOOP_ACQUIRE && clkOutEnable)
		else $error("acquisition not started on valid input");
	a_fast_bw: assert property (loopMode == LOOP_LOCKED |-> !fastBandwidthSel)
		else $error("fast bandwidth kept after lock");
	a_fast_acq: assert property (loopMode == LOOP_ACQUIRE && st_ff.fastApplied |-> fastBandwidthSel)
		else $error("fast bandwidth missing while acquiring");
	a_hist_freerun: assert property (st_ff.ctl == CTL_RUN && st_ff.mode == LOOP_LOCKED && !anyValid
		&& st_ff.pinS[1] && !hardReq |=> loopMode == ($past(st_ff.histS[1]) ? LOOP_HOLDOVER
		: LOOP_FREERUN))
		else $error("wrong mode on input loss");
	a_key_start: assert property (keyWr |=> (st_ff.ctl == CTL_PROG) == ($past(wrData) == WRITE_KEY
		&& $past(st_ff.writesDone) < $past(writeLimit)))
		else $error("memory write start does not match key");
	a_write_limit: assert property (st_ff.writesDone <= writeLimit || $changed(st_ff.strapS[1]))
		else $error("bank writes exceed limit");
	a_busy_code: assert property (st_ff.ctl == CTL_PROG || st_ff.ctl == CTL_RELOAD
		|-> readyByte != READY_CODE)
		else $error("ready shown while busy");
	a_ready_page: assert property (rdLoad && st_ff.shIn[14] && rdLo == READY_OFS
		|=> st_ff.shOut == $past(readyByte))
		else $error("readiness not returned on this page");
	a_soft_apply: assert property (st_ff.ctl == CTL_SOFT
		|=> st_ff.fastApplied == $past(st_ff.cfg[CFG_FAST][FAST_BIT]) && st_ff.ctl != CTL_INIT)
		else $error("soft reset did not apply configuration");
	a_hard_restart: assert property (hardReq |=> st_ff.ctl == CTL_INIT && st_ff.page == 8'h00
		&& !clkOutEnable ##[1:20] st_ff.ctl == CTL_RUN)
		else $error("hard reset did not restart");
	a_page_set: assert property (sckRise && st_ff.bitCnt == SPI_FRAME_LAST && !st_ff.csS[1]
		&& !st_ff.shIn[22] && st_ff.ctl == CTL_RUN && wrFull[7:0] == PAGE_OFS && st_ff.pinS[1]
		|=> st_ff.page == $past(wrData))
		else $error("page register write not taken");
	a_reload_done: assert property (st_ff.ctl == CTL_RELOAD |-> ##[1:16] st_ff.ctl != CTL_RELOAD)
		else $error("reload did not finish");
	a_prog_done: assert property (st_ff.ctl == CTL_PROG |-> ##[1:PROG_BOUND] st_ff.ctl != CTL_PROG)
		else $error("memory write did not finish");

	c_init_done: cover property (st_ff.ctl == CTL_INIT ##1 st_ff.ctl == CTL_RUN);
	c_prog_run: cover property (st_ff.ctl == CTL_PROG ##1 st_ff.ctl == CTL_RUN);
	c_holdover: cover property (loopMode == LOOP_LOCKED ##1 loopMode == LOOP_HOLDOVER);
	c_reload: cover property (st_ff.ctl == CTL_RELOAD ##1 st_ff.ctl == CTL_RUN);
	c_soft: cover property (st_ff.ctl == CTL_SOFT ##1 st_ff.ctl == CTL_RUN);
endmodule : cgn_ctrl

// File: rtl/cgn_nvm_mem.sv
`timescale 1ns/1ps
module cgn_nvm_mem
	import cgn_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 22,
	parameter int AW    = 5
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	// Write port
	input  wire logic             wrEn,
	input  wire logic [AW-1:0]    wrAddr,
	input  wire logic [WIDTH-1:0] wrData,
	// Read port
	input  wire logic [AW-1:0]    rdAddr,
	output logic      [WIDTH-1:0] rdData
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0]            rd;
	} cgn_mem_st_t;

	cgn_mem_st_t st_ff;
	cgn_mem_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (wrEn && int'(wrAddr) < DEPTH) begin
			nxt_st.mem[wrAddr] = wrData;
		end
		nxt_st.rd = (int'(rdAddr) < DEPTH) ? st_ff.mem[rdAddr] : '0;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rdData = st_ff.rd;
endmodule : cgn_nvm_mem

// File: rtl/cgn_pkg.sv
// Function
// - After power-up, load defaults from stored memory; serial traffic accepted only afterwards.
// - Every clock output stays inactive until initialization completes.
// - Reset pin or hard bit reloads all registers and restarts serial interface.
// - Writing 1 to the hard reset bit acts like a power cycle.
// - Writing 1 to soft reset applies pending changes without reloading memory.
// - Two memory writes on blank part, one on preprogrammed; older banks unreachable.
// - Readiness register is readable from every register page.
// - Memory write starts only when key 0xC7 is written.
// - Readiness reads 0x0F when ready; any other value means busy.
// - After host sets bank reload, device copies stored contents into registers.
// - Any hard reset loads the newest stored contents into registers.
// - User scratch registers exist for labelling the stored bank.
// - A readable register identifies the active stored bank.
// - After initialization the loop is in exactly one of four modes.
// - After initialization the loop enters free-run on its own.
// - Lock acquisition starts on its own when any input is valid.
// - Fast bandwidth used while acquiring if enabled, normal bandwidth afterwards.
// - Outputs keep running during lock acquisition.
// - Holdover entered when selected input fails and none other is valid.
// - Holdover only with valid history; otherwise free-run instead.
package cgn_pkg;
	localparam logic [7:0]  PAGE_OFS        = 8'h01;
	localparam logic [7:0]  READY_OFS       = 8'hfe;
	localparam logic [15:0] SOFT_RST_ADDR   = 16'h001c;
	localparam logic [15:0] HARD_RST_ADDR   = 16'h001e;
	localparam logic [15:0] BANK_ADDR       = 16'h00e2;
	localparam logic [15:0] KEY_ADDR        = 16'h00e3;
	localparam logic [15:0] RELOAD_ADDR     = 16'h00e4;
	localparam logic [15:0] SCRATCH_LO_ADDR = 16'h026b;
	localparam logic [15:0] SCRATCH_HI_ADDR = 16'h0272;
	localparam logic [15:0] FAST_ADDR       = 16'h052b;
	localparam logic [15:0] PROT0_ADDR      = 16'h0b24;
	localparam logic [15:0] PROT1_ADDR      = 16'h0b25;
	localparam int          SOFT_BIT        = 0;
	localparam int          HARD_BIT        = 1;
	localparam int          RELOAD_BIT      = 0;
	localparam int          FAST_BIT        = 0;
	localparam logic [7:0]  WRITE_KEY       = 8'hc7;
	localparam logic [7:0]  READY_CODE      = 8'h0f;
	localparam logic [7:0]  BUSY_CODE       = 8'h00;
	localparam int          CFG_BYTES       = 11;
	localparam logic [4:0]  CFG_FAST        = 5'h08;
	localparam logic [4:0]  CFG_PROT0       = 5'h09;
	localparam logic [4:0]  CFG_PROT1       = 5'h0a;
	localparam logic [7:0]  PROT0_RESET     = 8'hc3;
	localparam logic [7:0]  PROT1_RESET     = 8'h02;
	localparam logic [1:0]  WRITES_BLANK    = 2'h2;
	localparam logic [1:0]  WRITES_PRE      = 2'h1;
	localparam int          NVM_BANKS       = 2;
	localparam int          NVM_PROG_CYC    = 64;
	localparam logic [4:0]  SPI_HDR_LAST    = 5'h0f;
	localparam logic [4:0]  SPI_DATA_FIRST  = 5'h10;
	localparam logic [4:0]  SPI_FRAME_LAST  = 5'h17;
	localparam logic [4:0]  SPI_FRAME_BITS  = 5'h18;

	typedef enum logic [2:0] {
		CTL_INIT   = 3'b000,
		CTL_RUN    = 3'b001,
		CTL_SOFT   = 3'b010,
		CTL_PROG   = 3'b011,
		CTL_RELOAD = 3'b100
	} cgn_ctl_t;

	typedef enum logic [1:0] {
		LOOP_FREERUN  = 2'b00,
		LOOP_ACQUIRE  = 2'b01,
		LOOP_LOCKED   = 2'b10,
		LOOP_HOLDOVER = 2'b11
	} cgn_loop_t;

	// Image index of a full address; CFG_BYTES when not part of the image
	function automatic logic [4:0] cgn_cfg_idx(input logic [15:0] a);
		logic [15:0] d;
		d = a - SCRATCH_LO_ADDR;
		if (a >= SCRATCH_LO_ADDR && a <= SCRATCH_HI_ADDR) return d[4:0];
		if (a == FAST_ADDR) return CFG_FAST;
		if (a == PROT0_ADDR) return CFG_PROT0;
		if (a == PROT1_ADDR) return CFG_PROT1;
		return 5'(CFG_BYTES);
	endfunction : cgn_cfg_idx

	// Factory image used when no bank has been written
	function automatic logic [7:0] cgn_cfg_default(input logic [4:0] i);
		if (i == CFG_PROT0) return PROT0_RESET;
		if (i == CFG_PROT1) return PROT1_RESET;
		return 8'h00;
	endfunction : cgn_cfg_default
endpackage : cgn_pkg

// File: test/cgn_host_model.sv
`timescale 1ns/1ps
module cgn_host_model (
	// Clock
	input  wire logic ref_clk,
	// Serial port
	output logic      spiCsN,
	output logic      spiSck,
	output logic      spiMosi,
	input  wire logic spiMiso
);
	initial begin
		spiCsN  = 1'b1;
		spiSck  = 1'b0;
		spiMosi = 1'b1;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : hold

	// One frame, MSB first, clock idles low
	task automatic xfer(input logic rd, input logic [7:0] lo, input logic [7:0] wd,
		output logic [7:0] q);
		logic [23:0] f;
		f = {rd, 7'h00, lo, wd};
		q = 8'h00;
		spiCsN = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			spiMosi = f[i];
			hold(10);
			spiSck = 1'b1;
			if (i < 8) q = {q[6:0], spiMiso};
			hold(10);
			spiSck = 1'b0;
		end
		spiMosi = ~f[0];
		hold(10);
		spiCsN = 1'b1;
		hold(5);
	endtask : xfer
endmodule : cgn_host_model

// File: test/clock_gen_init_nvm_mode_control_bench.sv
`timescale 1ns/1ps
module clock_gen_init_nvm_mode_control_bench;
	import cgn_pkg::*;
	logic       ref_clk;
	logic       rstn;
	logic       restart_pin_n;
	logic       spiCsN;
	logic       spiSck;
	logic       spiMosi;
	logic       spiMiso;
	logic       spiMisoOe;
	logic       factoryPlan;
	logic [3:0] clkInValid;
	logic       lockAcquired;
	logic       history_valid_flag;
	logic       clkOutEnable;
	cgn_loop_t  loopMode;
	logic       fastBandwidthSel;
	logic       crystalRefOnly;
	int         offCount = 0;
	logic [7:0] q;
	int         failures;
	int         compares;

	cgn_ctrl #(.NUM_IN(4), .NVM_PROG_CYCLES(900)) cgn_ctrl_i (
		.ref_clk(ref_clk), .rstn(rstn), .restart_pin_n(restart_pin_n),
		.spiCsN(spiCsN), .spiSck(spiSck), .spiMosi(spiMosi), .spiMiso(spiMiso),
		.spiMisoOe(spiMisoOe), .factoryPlan(factoryPlan), .clkInValid(clkInValid),
		.lockAcquired(lockAcquired), .history_valid_flag(history_valid_flag),
		.clkOutEnable(clkOutEnable), .loopMode(loopMode),
		.fastBandwidthSel(fastBandwidthSel), .crystalRefOnly(crystalRefOnly)
	);

	cgn_host_model cgn_host_model_i (
		.ref_clk(ref_clk), .spiCsN(spiCsN), .spiSck(spiSck), .spiMosi(spiMosi),
		.spiMiso(spiMiso)
	);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (clkOutEnable !== 1'b1) offCount <= offCount + 1;
	end

	task automatic final_report;
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic tmo(input string n);
		failures++;
		$display("ERROR %s expected done seen timeout", n);
		final_report();
	endtask : tmo

	task automatic hold(input int n);
		cgn_host_model_i.hold(n);
	endtask : hold

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		cgn_host_model_i.xfer(1'b0, PAGE_OFS, a[15:8], q);
		cgn_host_model_i.xfer(1'b0, a[7:0], d, q);
	endtask : wr

	task automatic rchk(input string n, input logic [15:0] a, input logic [7:0] e);
		cgn_host_model_i.xfer(1'b0, PAGE_OFS, a[15:8], q);
		cgn_host_model_i.xfer(1'b1, a[7:0], 8'h00, q);
		chk(n, e, q);
	endtask : rchk

	// Only the readiness byte is read, no page change
	task automatic poll;
		for (int i = 0; i < 12; i++) begin
			cgn_host_model_i.xfer(1'b1, READY_OFS, 8'h00, q);
			if (q === READY_CODE) return;
		end
		tmo("ready");
	endtask : poll

	task automatic wait_out;
		for (int i = 0; i < 300; i++) begin
			if (clkOutEnable === 1'b1) return;
			hold(1);
		end
		tmo("clkOutEnable");
	endtask : wait_out

	task automatic wait_mode(input cgn_loop_t m);
		for (int i = 0; i < 40; i++) begin
			if (loopMode === m) return;
			hold(1);
		end
		tmo("loopMode");
	endtask : wait_mode

	task automatic t_init;
		chk("outEn init", 8'h00, {7'h00, clkOutEnable});
		chk("oe init", 8'h00, {7'h00, spiMisoOe});
		wait_out();
		chk("mode", 8'h00, {6'h00, loopMode});
		chk("xtalOnly", 8'h01, {7'h00, crystalRefOnly});
		poll();
	endtask : t_init

	task automatic t_regs;
		rchk("prot0", PROT0_ADDR, 8'hc3);
		rchk("prot1", PROT1_ADDR, 8'h02);
		rchk("hard", HARD_RST_ADDR, 8'h00);
		rchk("soft", SOFT_RST_ADDR, 8'h00);
		rchk("unmapped", 16'h0333, 8'h00);
		rchk("bank", BANK_ADDR, 8'h00);
	endtask : t_regs

	task automatic t_prot;
		wr(PROT0_ADDR, 8'hc0);
		wr(PROT1_ADDR, 8'h00);
		rchk("prot0", PROT0_ADDR, 8'hc0);
		hold(50);
		wr(FAST_ADDR, 8'h01);
		chk("fast pend", 8'h00, {7'h00, fastBandwidthSel});
		wr(SOFT_RST_ADDR, 8'h01);
		poll();
		wr(PROT0_ADDR, 8'hc3);
		wr(PROT1_ADDR, 8'h02);
		rchk("prot1", PROT1_ADDR, 8'h02);
		rchk("fastEn", FAST_ADDR, 8'h01);
	endtask : t_prot

	task automatic t_modes;
		clkInValid = 4'h2;
		wait_mode(LOOP_ACQUIRE);
		hold(3);
		chk("fastBw", 8'h01, {7'h00, fastBandwidthSel});
		chk("outEn acq", 8'h01, {7'h00, clkOutEnable});
		chk("xtalOnly", 8'h00, {7'h00, crystalRefOnly});
		lockAcquired = 1'b1;
		wait_mode(LOOP_LOCKED);
		hold(3);
		chk("fastBw", 8'h00, {7'h00, fastBandwidthSel});
		clkInValid = 4'h0;
		wait_mode(LOOP_FREERUN);
		clkInValid = 4'h1;
		wait_mode(LOOP_LOCKED);
		history_valid_flag = 1'b1;
		clkInValid = 4'h0;
		wait_mode(LOOP_HOLDOVER);
		lockAcquired = 1'b0;
	endtask : t_modes

	task automatic key(input logic [7:0] b);
		wr(KEY_ADDR, WRITE_KEY);
		poll();
		rchk("bank", BANK_ADDR, b);
	endtask : key

	task automatic t_nvm;
		wr(SCRATCH_LO_ADDR, 8'h5a);
		wr(KEY_ADDR, 8'h12);
		poll();
		rchk("bank bad key", BANK_ADDR, 8'h00);
		wr(KEY_ADDR, WRITE_KEY);
		cgn_host_model_i.xfer(1'b1, READY_OFS, 8'h00, q);
		chk("busy", BUSY_CODE, q);
		poll();
		rchk("bank", BANK_ADDR, 8'h01);
		rchk("key", KEY_ADDR, 8'h00);
		wr(SCRATCH_LO_ADDR, 8'h00);
		wr(RELOAD_ADDR, 8'h01);
		poll();
		rchk("scratch", SCRATCH_LO_ADDR, 8'h5a);
		rchk("reload", RELOAD_ADDR, 8'h00);
		key(8'h02);
		key(8'h02);
	endtask : t_nvm

	task automatic t_hard;
		int offBase;
		wr(SCRATCH_LO_ADDR, 8'h33);
		offBase = offCount;
		wr(HARD_RST_ADDR, 8'h02);
		hold(30);
		wait_out();
		chk("outEn off", 8'h01, {7'h00, offCount != offBase});
		rchk("scratch", SCRATCH_LO_ADDR, 8'h5a);
		restart_pin_n = 1'b0;
		hold(8);
		chk("outEn pin", 8'h00, {7'h00, clkOutEnable});
		chk("mode pin", 8'h00, {6'h00, loopMode});
		wr(SCRATCH_LO_ADDR, 8'h44);
		restart_pin_n = 1'b1;
		wait_out();
		rchk("scratch", SCRATCH_LO_ADDR, 8'h5a);
		rchk("bank", BANK_ADDR, 8'h02);
	endtask : t_hard

	task automatic t_factory;
		factoryPlan = 1'b1;
		rstn = 1'b0;
		hold(3);
		rstn = 1'b1;
		wait_out();
		rchk("bank", BANK_ADDR, 8'h00);
		key(8'h01);
		key(8'h01);
	endtask : t_factory

	initial begin
		failures = 0;
		compares = 0;
		rstn = 1'b0;
		restart_pin_n = 1'b1;
		factoryPlan = 1'b0;
		clkInValid = 4'h0;
		lockAcquired = 1'b0;
		history_valid_flag = 1'b0;
		hold(3);
		rstn = 1'b1;
		t_init();
		t_regs();
		t_prot();
		t_modes();
		t_nvm();
		t_hard();
		t_factory();
		final_report();
	end
endmodule : clock_gen_init_nvm_mode_control_bench
